/* File: hdl/slprc_consts.svh */
// offsets, field positions, reset values and timing counts of the sleep controller
`ifndef SLPRC_CONSTS_SVH
`define SLPRC_CONSTS_SVH
`define SLPRC_CLK_PERIOD_NS  100
`define SLPRC_ADR_W          4
`define SLPRC_ADR_SMC        4'h0
`define SLPRC_ADR_PRC        4'h4
`define SLPRC_ADR_STAT       4'h8
`define SLPRC_SE_BIT         0
`define SLPRC_SM_LSB         1
`define SLPRC_SM_MSB         3
`define SLPRC_PR_TIM_BIT     0
`define SLPRC_PR_ADC_BIT     1
`define SLPRC_MODE_IDLE      3'h0
`define SLPRC_MODE_ADCNR     3'h1
`define SLPRC_MODE_PDOWN     3'h2
`define SLPRC_MODE_STBY      3'h4
`define SLPRC_SMC_RESET      8'h00
`define SLPRC_PRC_RESET      8'h00
`define SLPRC_CNT_W          8
`define SLPRC_RST_DELAY_NS   1600
`define SLPRC_RST_DELAY_CYC  ((`SLPRC_RST_DELAY_NS + `SLPRC_CLK_PERIOD_NS - 1) / `SLPRC_CLK_PERIOD_NS)
`define SLPRC_OSC_START_NS   800
`define SLPRC_OSC_START_CYC  ((`SLPRC_OSC_START_NS + `SLPRC_CLK_PERIOD_NS - 1) / `SLPRC_CLK_PERIOD_NS)
`define SLPRC_WAKE_HALT_CYC  4
`endif

/* File: hdl/slprc_pkg.sv */
// types shared by the sleep controller modules
`include "slprc_consts.svh"
package slprc_pkg;
  typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_START, ST_HALT} slprc_state_t;

  typedef struct packed {
    logic                    rst;
    logic [`SLPRC_CNT_W-1:0] cnt;
  } slprc_rst_t;

  typedef struct packed {
    slprc_state_t            st;
    logic [2:0]              smode;
    logic [2:0]              mode;
    logic                    se;
    logic                    pr_tim;
    logic                    pr_adc;
    logic [`SLPRC_CNT_W-1:0] cnt;
    logic                    cpu_en;
    logic                    nvm_en;
    logic                    io_en;
    logic                    adc_en;
    logic                    osc_en;
    logic                    tim_en;
    logic                    cmp_off;
    logic                    adc_start;
    logic                    adc_ext;
    logic                    adc_prev;
    logic                    wdt_run;
    logic                    halt;
    logic                    irq_go;
    logic                    port_rst;
    logic                    ack;
    logic [7:0]              dat;
  } slprc_top_t;
endpackage

/* File: hdl/slprc_domain_map.sv */
// maps the active sleep mode onto the clock domain enables
`include "slprc_consts.svh"
module slprc_domain_map
  import slprc_pkg::*;
(
  input  wire logic [2:0] mode_i,
  input  wire logic       asleep_i,
  output logic            cpu_o,
  output logic            nvm_o,
  output logic            io_o,
  output logic            adc_o,
  output logic            osc_o,
  output logic            legal_o
);
  always_comb
  begin
    cpu_o   = !asleep_i;
    nvm_o   = !asleep_i;
    io_o    = 1'b1;
    adc_o   = 1'b1;
    osc_o   = 1'b1;
    legal_o = 1'b1;
    case (mode_i)
      `SLPRC_MODE_IDLE:
      begin
        io_o = 1'b1;
      end
      `SLPRC_MODE_ADCNR:
      begin
        io_o = !asleep_i;
      end
      `SLPRC_MODE_PDOWN:
      begin
        io_o  = !asleep_i;
        adc_o = !asleep_i;
        osc_o = !asleep_i;
      end
      `SLPRC_MODE_STBY:
      begin
        io_o  = !asleep_i;
        adc_o = !asleep_i;
      end
      default:
      begin
        legal_o = 1'b0;
      end
    endcase
  end
endmodule

/* File: hdl/slprc_reset_stretch.sv */
// holds the internal reset for a fixed count after every reset source is gone
`include "slprc_consts.svh"
module slprc_reset_stretch
  import slprc_pkg::*;
#(
  parameter logic [`SLPRC_CNT_W-1:0] DELAY = `SLPRC_CNT_W'(`SLPRC_RST_DELAY_CYC)
)
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic src_i,
  output logic      rst_o
);
  slprc_rst_t s;
  slprc_rst_t next_s;

  always_comb
  begin
    next_s = s;
    if (src_i)
    begin
      next_s.rst = 1'b1;
      next_s.cnt = DELAY;
    end
    else if (s.cnt != '0)
    begin
      next_s.cnt = s.cnt - 1'b1;
    end
    else
    begin
      next_s.rst = 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s.rst <= 1'b1;
      s.cnt <= DELAY;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign rst_o = s.rst;
endmodule

/* File: hdl/slprc_top.sv */
// sleep mode and peripheral clock gating controller with wishbone registers
`include "slprc_consts.svh"
module slprc_top
  import slprc_pkg::*;
(
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [`SLPRC_ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output logic      [31:0]            wb_dat_o,
  output logic                        wb_ack_o,
  input  wire logic                   sleep_req_i,
  input  wire logic                   irq_pending_i,
  input  wire logic                   ext_ext_interrupt_zero_level_i,
  input  wire logic                   pin_change_i,
  input  wire logic                   adc_irq_i,
  input  wire logic                   wdt_irq_i,
  input  wire logic                   vlm_irq_i,
  input  wire logic                   rst_src_i,
  input  wire logic                   adc_enable_i,
  input  wire logic                   adc_conv_done_i,
  input  wire logic                   wdt_enable_i,
  output logic                        cpu_clk_en_o,
  output logic                        progmem_clk_en_o,
  output logic                        io_clk_en_o,
  output logic                        adc_clk_en_o,
  output logic                        osc_en_o,
  output logic                        timer_clk_en_o,
  output logic                        timer_reg_access_o,
  output logic                        adc_reg_access_o,
  output logic                        comparator_mux_ok_o,
  output logic                        comparator_disable_o,
  output logic                        adc_start_o,
  output logic                        adc_extended_o,
  output logic                        input_buf_en_o,
  output logic                        wdt_run_o,
  output logic                        core_halt_o,
  output logic                        irq_resume_o,
  output logic                        core_reset_o,
  output logic                        port_reset_o
);
  localparam logic [`SLPRC_CNT_W-1:0] OSC_CNT  = `SLPRC_CNT_W'(`SLPRC_OSC_START_CYC - 1);
  localparam logic [`SLPRC_CNT_W-1:0] HALT_CNT = `SLPRC_CNT_W'(`SLPRC_WAKE_HALT_CYC - 1);
  slprc_top_t s;
  slprc_top_t next_s;
  slprc_top_t s_rst;
  logic core_rst;
  logic asleep;
  logic d_cpu;
  logic d_nvm;
  logic d_io;
  logic d_adc;
  logic d_osc;
  logic d_legal;
  logic m_legal;
  logic req;
  logic wake;
  slprc_reset_stretch u_stretch
  (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .src_i (rst_src_i),
    .rst_o (core_rst)
  );

  slprc_domain_map u_chk
  (
    .mode_i   (s.mode),
    .asleep_i (1'b0),
    .cpu_o    (),
    .nvm_o    (),
    .io_o     (),
    .adc_o    (),
    .osc_o    (),
    .legal_o  (m_legal)
  );

  slprc_domain_map u_map
  (
    .mode_i   (s.smode),
    .asleep_i (asleep),
    .cpu_o    (d_cpu),
    .nvm_o    (d_nvm),
    .io_o     (d_io),
    .adc_o    (d_adc),
    .osc_o    (d_osc),
    .legal_o  (d_legal)
  );

  assign asleep = (s.st == ST_SLEEP) || (s.st == ST_START);
  assign req    = wb_cyc_i && wb_stb_i && !s.ack;

  always_comb
  begin
    s_rst          = '0;
    s_rst.st       = ST_RUN;
    s_rst.mode     = 3'(`SLPRC_SMC_RESET >> `SLPRC_SM_LSB);
    s_rst.se       = 1'(`SLPRC_SMC_RESET >> `SLPRC_SE_BIT);
    s_rst.pr_tim   = 1'(`SLPRC_PRC_RESET >> `SLPRC_PR_TIM_BIT);
    s_rst.pr_adc   = 1'(`SLPRC_PRC_RESET >> `SLPRC_PR_ADC_BIT);
    s_rst.cpu_en   = 1'b1;
    s_rst.nvm_en   = 1'b1;
    s_rst.io_en    = 1'b1;
    s_rst.adc_en   = 1'b1;
    s_rst.osc_en   = 1'b1;
    s_rst.tim_en   = 1'b1;
    s_rst.adc_ext  = 1'b1;
    s_rst.halt     = 1'b1;
    s_rst.port_rst = 1'b1;
  end

  // wake sources depend on the latched mode; deep modes only see async wake logic
  always_comb
  begin
    case (s.smode)
      `SLPRC_MODE_IDLE:  wake = irq_pending_i;
      `SLPRC_MODE_ADCNR: wake = ext_ext_interrupt_zero_level_i || pin_change_i || adc_irq_i || wdt_irq_i || vlm_irq_i;
      default:           wake = ext_ext_interrupt_zero_level_i || pin_change_i;
    endcase
  end

  always_comb
  begin
    next_s           = s;
    next_s.adc_start = 1'b0;
    next_s.irq_go    = 1'b0;
    next_s.ack       = req;
    next_s.dat       = 8'h00;
    if (req && !wb_we_i)
    begin
      case (wb_adr_i)
        `SLPRC_ADR_SMC:  next_s.dat = {4'h0, s.mode, s.se};
        `SLPRC_ADR_PRC:  next_s.dat = {6'h00, s.pr_adc, s.pr_tim};
        `SLPRC_ADR_STAT: next_s.dat = {1'b0, s.st, s.smode, asleep, s.adc_ext};
        default:         next_s.dat = 8'h00;
      endcase
    end
    if (req && wb_we_i && wb_sel_i[0])
    begin
      case (wb_adr_i)
        `SLPRC_ADR_SMC:
        begin
          next_s.mode = wb_dat_i[`SLPRC_SM_MSB:`SLPRC_SM_LSB];
          next_s.se   = wb_dat_i[`SLPRC_SE_BIT];
        end
        `SLPRC_ADR_PRC:
        begin
          next_s.pr_tim = wb_dat_i[`SLPRC_PR_TIM_BIT];
          next_s.pr_adc = wb_dat_i[`SLPRC_PR_ADC_BIT];
        end
        default: next_s.mode = s.mode;
      endcase
    end

    case (s.st)
      ST_RUN:
      begin
        // reserved codes and a clear enable bit leave the instruction without effect
        if (sleep_req_i && s.se && m_legal)
        begin
          next_s.st    = ST_SLEEP;
          next_s.smode = s.mode;
          next_s.adc_start = (s.mode == `SLPRC_MODE_IDLE || s.mode == `SLPRC_MODE_ADCNR) && adc_enable_i;
          next_s.cmp_off   = (s.mode == `SLPRC_MODE_PDOWN || s.mode == `SLPRC_MODE_STBY);
        end
      end
      ST_SLEEP:
      begin
        if (wake)
        begin
          if (s.smode == `SLPRC_MODE_PDOWN)
          begin
            next_s.st  = ST_START;
            next_s.cnt = OSC_CNT;
          end
          else
          begin
            // standby skips start-up: its oscillator never stopped
            next_s.st  = ST_HALT;
            next_s.cnt = HALT_CNT;
          end
        end
      end
      ST_START:
      begin
        next_s.cnt = s.cnt - 1'b1;
        if (s.cnt == '0)
        begin
          next_s.st  = ST_HALT;
          next_s.cnt = HALT_CNT;
        end
      end
      ST_HALT:
      begin
        next_s.cnt = s.cnt - 1'b1;
        if (s.cnt == '0)
        begin
          next_s.st      = ST_RUN;
          next_s.irq_go  = 1'b1;
          next_s.cmp_off = 1'b0;
        end
      end
      default:
      begin
        next_s.st = ST_RUN;
      end
    endcase

    next_s.cpu_en = d_cpu && (s.st != ST_HALT);
    next_s.nvm_en = d_nvm;
    next_s.io_en  = d_io || !d_legal;
    next_s.adc_en = d_adc && !s.pr_adc;
    next_s.osc_en = d_osc || (s.st == ST_START);
    // gating the clock alone keeps timer state, so clearing the bit resumes it
    next_s.tim_en = d_io && !s.pr_tim;
    next_s.halt   = (s.st != ST_RUN);
    next_s.wdt_run = wdt_enable_i;

    next_s.adc_prev = adc_enable_i;
    if (adc_conv_done_i)
    begin
      next_s.adc_ext = 1'b0;
    end
    if (adc_enable_i && !s.adc_prev)
    begin
      next_s.adc_ext = 1'b1;
    end

    next_s.port_rst = rst_src_i || core_rst;
    if (core_rst)
    begin
      next_s          = s_rst;
      next_s.adc_prev = adc_enable_i;
      next_s.port_rst = 1'b1;
      next_s.ack      = req;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s <= s_rst;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign wb_dat_o             = {24'h000000, s.dat};
  assign wb_ack_o             = s.ack;
  assign cpu_clk_en_o         = s.cpu_en;
  assign progmem_clk_en_o     = s.nvm_en;
  assign io_clk_en_o          = s.io_en;
  assign adc_clk_en_o         = s.adc_en;
  assign osc_en_o             = s.osc_en;
  assign timer_clk_en_o       = s.tim_en;
  assign timer_reg_access_o   = s.tim_en;
  assign adc_reg_access_o     = s.adc_en;
  assign comparator_mux_ok_o  = !s.pr_adc;
  assign comparator_disable_o = s.cmp_off;
  assign adc_start_o          = s.adc_start;
  assign adc_extended_o       = s.adc_ext;
  assign input_buf_en_o       = s.io_en;
  assign wdt_run_o            = s.wdt_run;
  assign core_halt_o          = s.halt;
  assign irq_resume_o         = s.irq_go;
  assign core_reset_o         = core_rst;
  assign port_reset_o         = s.port_rst;

  property p_idle_dom;
    @(posedge clk_i) disable iff (rst_i)
    (s.st == ST_SLEEP && s.smode == `SLPRC_MODE_IDLE) ##1 (s.st == ST_SLEEP)
      |-> !cpu_clk_en_o && !progmem_clk_en_o && io_clk_en_o && osc_en_o;
  endproperty
  a_idle_dom: assert property (p_idle_dom) else $error("idle clock domains wrong");
  property p_nr_dom;
    @(posedge clk_i) disable iff (rst_i)
    (s.st == ST_SLEEP && s.smode == `SLPRC_MODE_ADCNR) ##1 (s.st == ST_SLEEP)
      |-> !io_clk_en_o && !cpu_clk_en_o && !input_buf_en_o;
  endproperty
  a_nr_dom: assert property (p_nr_dom) else $error("noise mode clock domains wrong");
  property p_pd_dom;
    @(posedge clk_i) disable iff (rst_i)
    (s.st == ST_SLEEP && s.smode == `SLPRC_MODE_PDOWN) ##1 (s.st == ST_SLEEP)
      |-> !osc_en_o && !adc_clk_en_o && !io_clk_en_o && comparator_disable_o;
  endproperty
  a_pd_dom: assert property (p_pd_dom) else $error("power-down clocks still on");
  property p_stby_dom;
    @(posedge clk_i) disable iff (rst_i)
    (s.st == ST_SLEEP && s.smode == `SLPRC_MODE_STBY) ##1 (s.st == ST_SLEEP)
      |-> osc_en_o && !io_clk_en_o && !adc_clk_en_o;
  endproperty
  a_stby_dom: assert property (p_stby_dom) else $error("standby oscillator stopped");
  property p_no_se;
    @(posedge clk_i) disable iff (rst_i)
    (s.st == ST_RUN && sleep_req_i && !s.se && !core_rst) |=> (s.st == ST_RUN) ##1 !core_halt_o;
  endproperty
  a_no_se: assert property (p_no_se) else $error("slept without enable bit");
  property p_adc_start;
    @(posedge clk_i) disable iff (rst_i)
    (s.st == ST_RUN && sleep_req_i && s.se && !core_rst && adc_enable_i
      && (s.mode == `SLPRC_MODE_IDLE || s.mode == `SLPRC_MODE_ADCNR)) |=> adc_start_o ##1 !adc_start_o;
  endproperty
  a_adc_start: assert property (p_adc_start) else $error("no conversion on sleep entry");
  property p_halt4;
    @(posedge clk_i) disable iff (rst_i || core_rst)
    $rose(s.st == ST_HALT) |-> (s.st == ST_HALT)[*4] ##1 (irq_resume_o && s.st == ST_RUN);
  endproperty
  a_halt4: assert property (p_halt4) else $error("wake halt not four cycles");
  property p_rsvd;
    @(posedge clk_i) disable iff (rst_i)
    (wb_ack_o && $past(!wb_we_i) && $past(wb_adr_i) == `SLPRC_ADR_SMC) |-> wb_dat_o[31:4] == 28'h0000000;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");
  property p_tim_stop;
    @(posedge clk_i) disable iff (rst_i)
    s.pr_tim |=> !timer_clk_en_o && !timer_reg_access_o;
  endproperty
  a_tim_stop: assert property (p_tim_stop) else $error("timer clock runs while stopped");
  property p_stretch;
    @(posedge clk_i) disable iff (rst_i)
    $fell(rst_src_i) |-> core_reset_o[*8] ##1 port_reset_o;
  endproperty
  a_stretch: assert property (p_stretch) else $error("internal reset not stretched");
  property p_rst_wake;
    @(posedge clk_i) disable iff (rst_i)
    (rst_src_i && asleep) |=> ##1 (s.st == ST_RUN && core_reset_o);
  endproperty
  a_rst_wake: assert property (p_rst_wake) else $error("reset did not leave sleep");

  c_idle_wake: cover property (@(posedge clk_i) disable iff (rst_i)
    s.st == ST_SLEEP && s.smode == `SLPRC_MODE_IDLE ##1 s.st == ST_HALT);
  c_pd_wake: cover property (@(posedge clk_i) disable iff (rst_i)
    s.st == ST_START ##1 s.st == ST_START);
  c_rst_sleep: cover property (@(posedge clk_i) disable iff (rst_i) rst_src_i && asleep);
endmodule

/* File: tb/slprc_core_model.sv */
// behavioural core model that issues the sleep instruction pulse
module slprc_core_model
(
  input  wire logic clk_i,
  input  wire logic halt_i,
  output logic      sleep_req_o
);
  timeunit 1ns;
  timeprecision 1ns;

  initial sleep_req_o = 1'b0;

  // a halted core executes nothing, so it never requests sleep while asleep
  task automatic exec_sleep();
    @(posedge clk_i);
    if (halt_i !== 1'b1)
    begin
      sleep_req_o <= 1'b1;
      @(posedge clk_i);
      sleep_req_o <= 1'b0;
    end
  endtask
endmodule

/* File: tb/tb_top.sv */
// self-checking bench for the sleep and clock gating controller
`include "slprc_consts.svh"
module tb_top;
  import slprc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [3:0]  wb_adr_i = 4'h0;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        sleep_req;
  logic        irq = 1'b0;
  logic        nr_irq = 1'b0;
  logic        ext_interrupt_zero = 1'b0;
  logic        pin = 1'b0;
  logic        rst_src = 1'b0;
  logic        adc_en = 1'b0;
  logic        adc_done = 1'b0;
  logic        wdt_en = 1'b0;
  logic        cpu, nvm, io, adc, osc, tim, tim_acc, adc_acc, mux_ok, cmp_dis;
  logic        adc_start, adc_ext, in_buf, wdt_run, halt, resume, core_rst, port_rst;
  int          n_mismatch = 0;
  int          tests_run = 0;

  always #50 clk_i = ~clk_i;

  slprc_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .sleep_req_i(sleep_req), .irq_pending_i(irq), .ext_ext_interrupt_zero_level_i(ext_interrupt_zero), .pin_change_i(pin),
    .adc_irq_i(nr_irq), .wdt_irq_i(nr_irq), .vlm_irq_i(nr_irq), .rst_src_i(rst_src), .adc_enable_i(adc_en),
    .adc_conv_done_i(adc_done), .wdt_enable_i(wdt_en), .cpu_clk_en_o(cpu), .progmem_clk_en_o(nvm),
    .io_clk_en_o(io), .adc_clk_en_o(adc), .osc_en_o(osc), .timer_clk_en_o(tim), .timer_reg_access_o(tim_acc),
    .adc_reg_access_o(adc_acc), .comparator_mux_ok_o(mux_ok), .comparator_disable_o(cmp_dis),
    .adc_start_o(adc_start), .adc_extended_o(adc_ext), .input_buf_en_o(in_buf), .wdt_run_o(wdt_run),
    .core_halt_o(halt), .irq_resume_o(resume), .core_reset_o(core_rst), .port_reset_o(port_rst));

  slprc_core_model core_u (.clk_i(clk_i), .halt_i(halt), .sleep_req_o(sleep_req));

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // holds the request until ack is sampled high, then releases for one cycle
  task automatic wb_xfer(input logic we, input logic [3:0] adr, input logic [7:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= {24'h0, wd};
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50)
      n_mismatch++;
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wb_wr(input logic [3:0] adr, input logic [7:0] wd);
    logic [31:0] r;
    wb_xfer(1'b1, adr, wd, r);
  endtask

  task automatic rd_chk(input logic [3:0] adr, input logic [31:0] exp);
    logic [31:0] r;
    wb_xfer(1'b0, adr, 8'h00, r);
    check("rdata", r, exp);
  endtask

  task automatic wait_rst();
    int n;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (core_rst !== 1'b0 && n < 100);
    if (core_rst !== 1'b0)
      n_mismatch++;
  endtask

  // {cpu, progmem, io, adc, osc, comparator off}; reserved codes leave everything running
  function automatic logic [5:0] exp_dom(input logic [2:0] m);
    case (m)
      `SLPRC_MODE_IDLE:  return 6'b001110;
      `SLPRC_MODE_ADCNR: return 6'b000110;
      `SLPRC_MODE_PDOWN: return 6'b000001;
      `SLPRC_MODE_STBY:  return 6'b000011;
      default:           return 6'b111110;
    endcase
  endfunction

  initial
  begin
    #(5_000_000);
    n_mismatch++;
    print_verdict();
  end

  initial
  begin
    logic [5:0] e;
    logic       lg;
    int         n;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    @(negedge clk_i);
    check("core_rst", core_rst, 1);
    check("port_rst", port_rst, 1);
    check("adc_ext", adc_ext, 1);
    wait_rst();
    rd_chk(`SLPRC_ADR_SMC, 0);
    rd_chk(`SLPRC_ADR_PRC, 0);
    wb_wr(`SLPRC_ADR_SMC, 8'hFF);
    rd_chk(`SLPRC_ADR_SMC, 32'h0F);
    wb_wr(`SLPRC_ADR_PRC, 8'hFF);
    rd_chk(`SLPRC_ADR_PRC, 32'h03);
    wb_wr(4'hC, 8'hFF);
    rd_chk(4'hC, 0);
    for (int v = 2; v >= 0; v--)
    begin
      wb_wr(`SLPRC_ADR_PRC, 8'(v));
      @(negedge clk_i);
      check("timer_clk", tim, !v[0]);
      check("timer_acc", tim_acc, !v[0]);
      check("adc_acc", adc_acc, !v[1]);
      check("cmp_mux", mux_ok, !v[1]);
    end
    @(posedge clk_i);
    adc_done <= 1'b1;
    wdt_en <= 1'b1;
    @(posedge clk_i);
    adc_done <= 1'b0;
    @(negedge clk_i);
    check("adc_ext_done", adc_ext, 0);
    @(posedge clk_i);
    adc_en <= 1'b1;
    repeat (3) @(negedge clk_i);
    check("adc_ext_on", adc_ext, 1);
    for (int m = 0; m < 8; m++)
    begin
      lg = (m == 0) || (m == 1) || (m == 2) || (m == 4);
      wb_wr(`SLPRC_ADR_SMC, {4'h0, 3'(m), 1'b1});
      core_u.exec_sleep();
      @(negedge clk_i);
      check("adc_start", adc_start, lg && m < 2);
      @(negedge clk_i);
      check("halt", halt, lg);
      e = exp_dom(3'(m));
      check("domains", {cpu, nvm, io, adc, osc, cmp_dis}, e);
      check("in_buf", in_buf, e[3]);
      check("timer_run", tim, e[3]);
      check("wdt_run", wdt_run, 1);
      if (lg)
      begin
        if (m != 0)
        begin
          @(posedge clk_i);
          irq <= 1'b1;
          nr_irq <= (m != 1);
          repeat (10) @(negedge clk_i);
          check("no_wake", halt, 1);
          @(posedge clk_i);
          irq <= 1'b0;
          nr_irq <= 1'b0;
        end
        @(posedge clk_i);
        if (m == 0)
          irq <= 1'b1;
        else if (m == 4)
          pin <= 1'b1;
        else if (m == 1)
          nr_irq <= 1'b1;
        else
          ext_interrupt_zero <= 1'b1;
        n = 0;
        do
        begin
          @(negedge clk_i);
          n++;
        end
        while (resume !== 1'b1 && n < 40);
        check("wake_cyc", n, (m == 2) ? 14 : 6);
        @(posedge clk_i);
        irq <= 1'b0;
        pin <= 1'b0;
        ext_interrupt_zero <= 1'b0;
        nr_irq <= 1'b0;
      end
      wb_wr(`SLPRC_ADR_SMC, 8'h00);
    end
    core_u.exec_sleep();
    repeat (2) @(negedge clk_i);
    check("no_se_halt", halt, 0);
    wb_wr(`SLPRC_ADR_SMC, 8'h05);
    core_u.exec_sleep();
    repeat (3) @(posedge clk_i);
    rst_src <= 1'b1;
    repeat (2) @(negedge clk_i);
    check("port_rst_src", port_rst, 1);
    check("core_rst_src", core_rst, 1);
    @(posedge clk_i);
    rst_src <= 1'b0;
    repeat (10) @(negedge clk_i);
    check("stretch", core_rst, 1);
    wait_rst();
    repeat (2) @(negedge clk_i);
    check("run_after", {halt, cpu}, 2'b01);
    rd_chk(`SLPRC_ADR_SMC, 0);
    print_verdict();
  end
endmodule
